/* hw/leaky_bucket.v */
// one token bucket: credit per window, debit per frame byte count
`timescale 1ns/1ps
module leaky_bucket
(
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    input  wire        win_tick,
    input  wire [23:0] credit,
    input  wire        unlimited,
    input  wire        debit,
    input  wire [15:0] debit_bytes,
    output wire        over
);
    reg [23:0] used_r;
    reg [23:0] used_nxt;
    wire [23:0] debit_bits = {5'h00, debit_bytes, 3'h0};

    always @*
    begin
        used_nxt = used_r;
        if (win_tick)
            used_nxt = (used_r > credit) ? used_r - credit : 24'h000000;
        if (debit)
            used_nxt = used_nxt + debit_bits;
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            used_r <= 24'h000000;
        else if (clk_en)
            used_r <= used_nxt;
    end

    // bucket overflows once a window's worth of bits is outstanding
    assign over = !unlimited && (used_r >= credit);
endmodule // leaky_bucket

/* hw/port_rate_limiter.v */
// per-port ingress metering and egress shaping for one switch port
`timescale 1ns/1ps
`include "rate_limiter_map.vh"
module port_rate_limiter
(
    input  wire         sys_clk,
    input  wire         rst_b,
    input  wire         clk_en,
    input  wire         speed_10,
    input  wire [7:0]   rate_ctrl,
    input  wire [7:0]   port_ctrl0,
    input  wire [7:0]   global_ctrl19,
    input  wire [1:0]   prio_src,
    input  wire [1:0]   queue_mode,
    input  wire         size_add_ifg,
    input  wire         size_add_pre,
    input  wire [15:0]  remap_1p,
    input  wire [127:0] remap_ds,
    input  wire         remap_load,
    input  wire [27:0]  ing_rate,
    input  wire [27:0]  egr_rate,
    input  wire [27:0]  tx_ratio,
    input  wire         rx_sof,
    input  wire [15:0]  rx_len,
    input  wire         rx_mcast,
    input  wire         rx_bcast,
    input  wire         rx_flood,
    input  wire [2:0]   rx_pcp,
    input  wire [5:0]   rx_dscp,
    output reg          rx_drop,
    output reg          rx_pause,
    output reg  [1:0]   rx_prio,
    input  wire [3:0]   txq_valid,
    input  wire [63:0]  txq_len,
    output reg  [3:0]   txq_grant,
    input  wire         tx_done,
    output wire         tx_busy,
    output wire [3:0]   egr_over
);
    // table: code -> kbps, codes 1..15 sub-1M, 16+ whole Mbps, 0 = off
    function [23:0] rate_bits;
        input [6:0] code;
        begin
            if (code == 7'h00)
                rate_bits = 24'h000000;
            else if (code < `SUB1M_STEPS)
                rate_bits = {17'h00000, code} * `STEP_KBPS;
            else
                rate_bits = ({17'h00000, code} - {17'h00000, `SUB1M_STEPS} + 24'h000001)
                            * `STEP_MBPS_KBPS;
        end
    endfunction

    function lim_off;
        input [6:0] code;
        input       gate;
        begin
            // above ten on a 10 Mbps port is no limit
            lim_off = !gate || code == 7'h00 ||
                      (speed_10 && rate_bits(code) > `TEN_MBPS_KBPS);
        end
    endfunction

    function [6:0] fld;
        input [27:0] v;
        input [1:0]  i;
        begin
            fld = v[i*7 +: 7];
        end
    endfunction

    reg  [16:0] win_cnt_r;
    reg         win_tick_r;
    reg  [15:0] remap_1p_r;
    reg  [127:0] remap_ds_r;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            win_cnt_r  <= 17'h00000;
            win_tick_r <= 1'b0;
        end
        else if (clk_en)
        begin
            win_tick_r <= (win_cnt_r == `WINDOW_CYC - 1);
            win_cnt_r  <= (win_cnt_r == `WINDOW_CYC - 1) ? 17'h00000 : win_cnt_r + 17'h00001;
        end
    end

    // remap tables with defaults, reloaded by software
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remap_1p_r <= `REMAP_1P_RST;
            remap_ds_r <= `REMAP_DS_RST;
        end
        else if (clk_en && remap_load)
        begin
            remap_1p_r <= remap_1p;
            remap_ds_r <= remap_ds;
        end
    end

    reg [1:0] prio_c;
    always @*
    begin
        case (prio_src)
            `PSRC_DOT1P: prio_c = remap_1p_r[rx_pcp*2 +: 2];
            `PSRC_DSCP:  prio_c = remap_ds_r[rx_dscp*2 +: 2];
            default:     prio_c = port_ctrl0[`PPRI_MSB:`PPRI_LSB];
        endcase
    end

    // queue limiting of queues 1-3 gated by global bit, queue 0 always limited
    wire        qlim_en = global_ctrl19[`QLIM_EN_BIT];
    wire [1:0]  qmask_top = (queue_mode == `QMODE_FOUR) ? 2'h3 :
                            (queue_mode == `QMODE_TWO) ? 2'h1 : 2'h0;
    wire [1:0]  rx_q = (prio_c > qmask_top) ? qmask_top : prio_c;

    function [15:0] frame_size;
        input [15:0] len;
        begin
            frame_size = len + (size_add_ifg ? {8'h00, `IFG_BYTES} : 16'h0000)
                             + (size_add_pre ? {8'h00, `PRE_BYTES} : 16'h0000);
        end
    endfunction

    // class select, meter only matching frames
    reg cls_hit;
    always @*
    begin
        case (rate_ctrl[`FSEL_MSB:`FSEL_LSB])
            `FCLS_ALL:   cls_hit = 1'b1;
            `FCLS_MCAST: cls_hit = rx_mcast;
            `FCLS_BCAST: cls_hit = rx_bcast;
            `FCLS_FLOOD: cls_hit = rx_flood;
            default:     cls_hit = 1'b0;
        endcase
    end

    wire [3:0] ing_over;
    wire       rx_drop_c;
    wire [3:0] egr_over_w;
    reg  [3:0] txq_sent;
    wire [1:0] tx_q;
    reg  [1:0] cur_q_r;

    // separate ingress and egress buckets per priority
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : bk
            leaky_bucket u_ing
            (
                .sys_clk     (sys_clk),
                .rst_b       (rst_b),
                .clk_en      (clk_en),
                .win_tick    (win_tick_r),
                .credit      (rate_bits(fld(ing_rate, g))),
                .unlimited   (lim_off(fld(ing_rate, g), qlim_en || g == 0)
                              || g > qmask_top),
                .debit       (rx_sof && cls_hit && rx_q == g && !rx_drop_c),
                .debit_bytes (frame_size(rx_len)),
                .over        (ing_over[g])
            );
            leaky_bucket u_egr
            (
                .sys_clk     (sys_clk),
                .rst_b       (rst_b),
                .clk_en      (clk_en),
                .win_tick    (win_tick_r),
                .credit      (rate_bits(fld(egr_rate, g))),
                .unlimited   (lim_off(fld(egr_rate, g), qlim_en || g == 0)
                              || g > qmask_top),
                .debit       (txq_sent[g]),
                .debit_bytes (frame_size(txq_len[g*16 +: 16])),
                .over        (egr_over_w[g])
            );
        end
    endgenerate
    assign egr_over = egr_over_w;

    assign rx_drop_c = cls_hit && ing_over[rx_q] && !rate_ctrl[`IFC_BIT];
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_drop  <= 1'b0;
            rx_pause <= 1'b0;
            rx_prio  <= 2'h0;
        end
        else if (clk_en)
        begin
            rx_drop  <= rx_sof && rx_drop_c;
            rx_pause <= rate_ctrl[`IFC_BIT] && |ing_over;
            if (rx_sof)
                rx_prio <= prio_c;
        end
    end

    // ratio credits, reloaded once no valid queue is eligible
    reg [6:0] ratio_cnt_r [0:3];
    wire [6:0] ratio_rst [0:3];
    assign ratio_rst[0] = `RATIO0_RST;
    assign ratio_rst[1] = `RATIO1_RST;
    assign ratio_rst[2] = `RATIO2_RST;
    assign ratio_rst[3] = `RATIO3_RST;

    localparam ST_IDLE = 2'h0;
    localparam ST_SEND = 2'h1;
    localparam ST_GAP  = 2'h2;
    reg [1:0]  state_r;
    reg [15:0] gap_r;

    // top queue exempt from ratio, over-rate queues just wait
    reg [3:0] elig;
    integer k;
    integer m;
    always @*
    begin
        for (k = 0; k < 4; k = k + 1)
            elig[k] = txq_valid[k] && !egr_over_w[k] && k <= qmask_top
                      && (k == qmask_top || ratio_cnt_r[k] != 7'h00);
    end
    assign tx_q = elig[3] ? 2'h3 : elig[2] ? 2'h2 : elig[1] ? 2'h1 : 2'h0;
    wire ratio_reload = !(|elig) && |txq_valid;

    always @*
    begin
        txq_sent = 4'h0;
        if (state_r == ST_IDLE && |elig)
            txq_sent[tx_q] = 1'b1;
    end

    always @*
    begin
        txq_grant = txq_sent;
    end
    assign tx_busy = state_r != ST_IDLE;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            cur_q_r <= 2'h0;
            gap_r   <= 16'h0000;
            ratio_cnt_r[0] <= `RATIO0_RST;
            ratio_cnt_r[1] <= `RATIO1_RST;
            ratio_cnt_r[2] <= `RATIO2_RST;
            ratio_cnt_r[3] <= `RATIO3_RST;
        end
        else if (clk_en)
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (|elig)
                    begin
                        cur_q_r <= tx_q;
                        state_r <= ST_SEND;
                        // gap stretch scales with frame size
                        gap_r <= frame_size(txq_len[tx_q*16 +: 16]);
                        if (tx_q != qmask_top)
                            ratio_cnt_r[tx_q] <= ratio_cnt_r[tx_q] - 7'h01;
                    end
                    else if (ratio_reload)
                    begin
                        for (m = 0; m < 4; m = m + 1)
                            ratio_cnt_r[m] <= (fld(tx_ratio, m[1:0]) == 7'h00) ?
                                              ratio_rst[m] : fld(tx_ratio, m[1:0]);
                    end
                end
                ST_SEND:
                    if (tx_done)
                        state_r <= egr_over_w[cur_q_r] ? ST_GAP : ST_IDLE;
                ST_GAP:
                begin
                    // hold off until the gap expires
                    gap_r <= gap_r - 16'h0001;
                    if (gap_r <= 16'h0001)
                        state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // port_rate_limiter

/* hw/rate_limiter_map.vh */
// constants for the per-port rate limiter
`ifndef RATE_LIMITER_MAP_VH
`define RATE_LIMITER_MAP_VH
`define FSEL_LSB        2
`define FSEL_MSB        3
`define IFC_BIT         4
`define PPRI_LSB        3
`define PPRI_MSB        4
`define QLIM_EN_BIT     3
`define RATE_MSB        6
`define FCLS_ALL        2'h0
`define FCLS_MCAST      2'h1
`define FCLS_BCAST      2'h2
`define FCLS_FLOOD      2'h3
`define PSRC_PORT       2'h0
`define PSRC_DOT1P      2'h1
`define PSRC_DSCP       2'h2
`define QMODE_ONE       2'h0
`define QMODE_TWO       2'h1
`define QMODE_FOUR      2'h2
`define SUB1M_STEPS     7'h10
`define STEP_KBPS       24'h000040
`define STEP_MBPS_KBPS  24'h0003E8
`define TEN_MBPS_KBPS   24'h002710
`define WINDOW_US       1000
`define CLK_MHZ         125
`define WINDOW_CYC      (`WINDOW_US * `CLK_MHZ)
`define IFG_BYTES       8'h0C
`define PRE_BYTES       8'h08
`define REMAP_1P_RST    16'hFA50
`define REMAP_DS_RST    128'h0
`define RATIO0_RST      7'h08
`define RATIO1_RST      7'h04
`define RATIO2_RST      7'h02
`define RATIO3_RST      7'h01
`endif

/* tb/port_rate_limiter_props.sv */
// port-level assertions for the rate limiter
`timescale 1ns/1ps
module port_rate_limiter_props
(
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic [7:0] rate_ctrl,
    input wire logic [7:0] port_ctrl0,
    input wire logic [1:0] prio_src,
    input wire logic       rx_sof,
    input wire logic       rx_drop,
    input wire logic [1:0] rx_prio,
    input wire logic [3:0] txq_valid,
    input wire logic [3:0] txq_grant,
    input wire logic       tx_busy,
    input wire logic [3:0] egr_over
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_b);
sequence s_take; clk_en && rx_sof; endsequence
sequence s_grant; clk_en && txq_grant != 4'h0; endsequence
property p_drop; rx_drop && $past(clk_en) |-> $past(rx_sof && !rate_ctrl[4]); endproperty
property p_prio; s_take ##0 prio_src == 2'h0 |=> rx_prio == $past(port_ctrl0[4:3]); endproperty
property p_hold; !clk_en |=> $stable(rx_prio); endproperty
property p_valid; s_grant |-> (txq_grant & ~txq_valid) == 4'h0; endproperty
property p_one; s_grant |-> $onehot(txq_grant); endproperty
property p_busy; s_grant |=> tx_busy; endproperty
property p_excl; tx_busy |-> txq_grant == 4'h0; endproperty
property p_q0; txq_grant[0] |-> !egr_over[0]; endproperty
a_drop: assert property (p_drop) else $error("drop without frame");
a_prio: assert property (p_prio) else $error("port priority wrong");
a_hold: assert property (p_hold) else $error("state moved while frozen");
a_valid: assert property (p_valid) else $error("grant to empty queue");
a_one: assert property (p_one) else $error("several grants");
a_busy: assert property (p_busy) else $error("no busy after grant");
a_excl: assert property (p_excl) else $error("grant while busy");
a_q0: assert property (p_q0) else $error("grant to over-rate queue");
endmodule // port_rate_limiter_props
bind port_rate_limiter port_rate_limiter_props u_props (.sys_clk, .rst_b, .clk_en, .rate_ctrl,
    .port_ctrl0, .prio_src, .rx_sof, .rx_drop, .rx_prio, .txq_valid, .txq_grant, .tx_busy,
    .egr_over);

/* tb/test_port_rate_limiter.sv */
// self-checking bench for the per-port rate limiter
`timescale 1ns/1ps
module test_port_rate_limiter;
reg          sys_clk, rst_b, clk_en, speed_10, rx_sof, rx_mcast, rx_bcast, rx_flood;
reg          size_add_ifg, size_add_pre, remap_load;
reg  [7:0]   rate_ctrl, port_ctrl0, global_ctrl19;
reg  [1:0]   prio_src, queue_mode;
reg  [15:0]  remap_1p, rx_len;
reg  [127:0] remap_ds;
reg  [27:0]  ing_rate, egr_rate, tx_ratio;
reg  [2:0]   rx_pcp;
reg  [5:0]   rx_dscp;
wire         rx_drop, rx_pause, tx_done, tx_busy;
wire [1:0]   rx_prio;
wire [3:0]   txq_valid, txq_grant, egr_over;
wire [63:0]  txq_len;
reg  [2:0]   hit [0:3];
integer      mismatches, checks, grants, cyc, i;
port_rate_limiter u_dut
(
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .clk_en        (clk_en),
    .speed_10      (speed_10),
    .rate_ctrl     (rate_ctrl),
    .port_ctrl0    (port_ctrl0),
    .global_ctrl19 (global_ctrl19),
    .prio_src      (prio_src),
    .queue_mode    (queue_mode),
    .size_add_ifg  (size_add_ifg),
    .size_add_pre  (size_add_pre),
    .remap_1p      (remap_1p),
    .remap_ds      (remap_ds),
    .remap_load    (remap_load),
    .ing_rate      (ing_rate),
    .egr_rate      (egr_rate),
    .tx_ratio      (tx_ratio),
    .rx_sof        (rx_sof),
    .rx_len        (rx_len),
    .rx_mcast      (rx_mcast),
    .rx_bcast      (rx_bcast),
    .rx_flood      (rx_flood),
    .rx_pcp        (rx_pcp),
    .rx_dscp       (rx_dscp),
    .rx_drop       (rx_drop),
    .rx_pause      (rx_pause),
    .rx_prio       (rx_prio),
    .txq_valid     (txq_valid),
    .txq_len       (txq_len),
    .txq_grant     (txq_grant),
    .tx_done       (tx_done),
    .tx_busy       (tx_busy),
    .egr_over      (egr_over)
);
tx_queue_model u_peer (.sys_clk, .txq_grant, .txq_valid, .txq_len, .tx_done);
initial
begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
end
task chk(input [15:0] got, input [15:0] exp, input [8*10-1:0] msg);
begin
    checks = checks + 1;
    if (got !== exp)
    begin
        mismatches = mismatches + 1;
        $display("mismatch t=%0t %0s got %h exp %h", $time, msg, got, exp);
    end
end
endtask
task frame(input [2:0] k, input [2:0] pcp);
begin
    {rx_mcast, rx_bcast, rx_flood} = k;
    rx_pcp = pcp;
    rx_sof = 1'b1;
    @(negedge sys_clk);
    rx_sof = 1'b0;
end
endtask
task conclude;
begin
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
end
endtask
// one metered class per priority bucket, so each class starts empty
task t_class;
begin
    for (i = 0; i < 4; i = i + 1)
    begin
        rate_ctrl  = {4'h0, i[1:0], 2'h0};
        port_ctrl0 = {3'h0, i[1:0], 3'h0};
        if (i != 0)
        begin
            frame(3'h0, 3'h0);
            chk(rx_drop, 0, "other cls");
        end
        frame(hit[i], 3'h0);
        chk(rx_drop, 0, "first");
        frame(hit[i], 3'h0);
        chk(rx_drop, 1, "over");
    end
    rate_ctrl = 8'h1C;
    frame(3'h1, 3'h0);
    chk(rx_drop, 0, "pause drop");
    chk(rx_pause, 1, "pause");
    $display("t_class done");
end
endtask
task t_prio;
begin
    prio_src = 2'h1;
    for (i = 0; i < 8; i = i + 1)
    begin
        frame(3'h0, i[2:0]);
        chk(rx_prio, i / 2, "pcp prio");
    end
    remap_1p = 16'hFFFF;
    remap_load = 1'b1;
    @(negedge sys_clk);
    remap_load = 1'b0;
    frame(3'h0, 3'h0);
    chk(rx_prio, 3, "loaded");
    prio_src = 2'h2;
    frame(3'h0, 3'h7);
    chk(rx_prio, 0, "ds prio");
    prio_src = 2'h0;
    port_ctrl0 = 8'h10;
    frame(3'h0, 3'h0);
    chk(rx_prio, 2, "port prio");
    clk_en = 1'b0;
    port_ctrl0 = 8'h08;
    frame(3'h0, 3'h0);
    chk(rx_prio, 2, "frozen");
    clk_en = 1'b1;
    $display("t_prio done");
end
endtask
task t_ten;
begin
    ing_rate = {4{7'h1A}};
    rate_ctrl = 8'h08;
    port_ctrl0 = 8'h10;
    frame(3'h2, 3'h0);
    chk(rx_drop, 1, "11M full");
    speed_10 = 1'b1;
    frame(3'h2, 3'h0);
    chk(rx_drop, 0, "10M free");
    speed_10 = 1'b0;
    global_ctrl19 = 8'h00;
    frame(3'h2, 3'h0);
    chk(rx_drop, 0, "no qlimit");
    $display("t_ten done");
end
endtask
// limited queue 0 keeps its backlog while queue 1 still flows
task t_egr;
begin
    global_ctrl19 = 8'h08;
    egr_rate = 28'h0000001;
    u_peer.add(2'h0, 8'h02);
    repeat (300) @(negedge sys_clk);
    chk(grants, 1, "q0 grants");
    chk(egr_over[0], 1, "q0 over");
    chk(txq_valid[0], 1, "q0 kept");
    u_peer.hold = 8'h14;
    u_peer.add(2'h1, 8'h02);
    repeat (300) @(negedge sys_clk);
    chk(grants, 3, "q1 grants");
    $display("t_egr done");
end
endtask
always @(posedge sys_clk)
begin
    cyc = cyc + 1;
    if (txq_grant != 4'h0)
        grants = grants + 1;
    if (cyc == 20000)
    begin
        mismatches = mismatches + 1;
        conclude;
    end
end
initial
begin
    {rst_b, rx_sof, rx_mcast, rx_bcast, rx_flood, speed_10, remap_load} = 7'h00;
    {size_add_pre, prio_src, rx_pcp, rx_dscp, port_ctrl0, tx_ratio} = 0;
    clk_en = 1'b1; size_add_ifg = 1'b1; queue_mode = 2'h2; global_ctrl19 = 8'h08;
    rate_ctrl = 8'h00; remap_1p = 16'hFA50; remap_ds = 128'h0; rx_len = 16'h05DC;
    ing_rate = {4{7'h01}}; egr_rate = 28'h0;
    hit[0] = 3'h0; hit[1] = 3'h4; hit[2] = 3'h2; hit[3] = 3'h1;
    mismatches = 0; checks = 0; grants = 0; cyc = 0;
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    chk({rx_drop, rx_pause, rx_prio, txq_grant}, 0, "reset");
    t_class;
    t_prio;
    t_ten;
    t_egr;
    conclude;
end
endmodule // test_port_rate_limiter

/* tb/tx_queue_model.sv */
// egress queue and transmitter model facing the scheduler
`timescale 1ns/1ps
module tx_queue_model
(
    input  wire        sys_clk,
    input  wire [3:0]  txq_grant,
    output wire [3:0]  txq_valid,
    output wire [63:0] txq_len,
    output reg         tx_done
);
reg  [7:0]  cnt [0:3];
reg  [7:0]  hold;
reg  [7:0]  left;
reg  [1:0]  cur;
reg         act;
assign txq_len   = {4{16'h0040}};
assign txq_valid = {cnt[3] != 8'h00, cnt[2] != 8'h00, cnt[1] != 8'h00, cnt[0] != 8'h00};
initial
begin
    cnt[0] = 8'h00; cnt[1] = 8'h00; cnt[2] = 8'h00; cnt[3] = 8'h00;
    hold = 8'h02; left = 8'h00; cur = 2'h0; act = 1'b0; tx_done = 1'b0;
end
// frames queue up; backlog stays valid until sent
task add(input [1:0] q, input [7:0] n);
    cnt[q] <= cnt[q] + n;
endtask
// grant lasts one cycle, so it must be seen on the edge the scheduler takes it
always @(posedge sys_clk)
begin
    tx_done <= 1'b0;
    if (act && left == 8'h00)
    begin
        tx_done     <= 1'b1;
        cnt[cur]    <= cnt[cur] - 8'h01;
        act         <= 1'b0;
    end
    else if (act)
        left <= left - 8'h01;
    if (txq_grant != 4'h0)
    begin
        act  <= 1'b1;
        left <= hold;
        cur  <= txq_grant[3] ? 2'h3 : txq_grant[2] ? 2'h2 : txq_grant[1] ? 2'h1 : 2'h0;
    end
end
endmodule // tx_queue_model
